//--- hw/ats_pkg.sv
package ats_pkg;
    // ==========================================================
    // timing
    localparam int unsigned SYS_CLK_HZ = 250_000_000;
    localparam int unsigned BURST_CLK_HZ = 20_000_000;
    // rounded up: the burst clock never runs above its nominal rate
    localparam int unsigned BURST_DIV = (SYS_CLK_HZ + BURST_CLK_HZ - 1) / BURST_CLK_HZ;
    localparam logic [7:0] BURST_DIV_M1 = 8'(BURST_DIV - 1);
    localparam logic [7:0] CONV_CLKS = 8'h0d;
    localparam logic [7:0] LP_TRACK_CLKS = 8'h03;
    localparam int unsigned PWRUP_SHIFT = 3;
    // ==========================================================
    // widths and register map
    localparam int unsigned DATA_W = 10;
    localparam int unsigned ACC_W = 16;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_WIN_GT = 8'h08;
    localparam logic [7:0] OFS_WIN_LT = 8'h0c;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int unsigned CTRL_EN = 7;
    localparam int unsigned CTRL_BURST = 6;
    localparam int unsigned CTRL_DONE = 5;
    localparam int unsigned CTRL_BUSY = 4;
    localparam int unsigned CTRL_WIN = 3;
    localparam int unsigned CTRL_LPT = 2;
    localparam int unsigned CTRL_SRC_LSB = 8;
    localparam int unsigned CFG_RPT_LSB = 0;
    localparam int unsigned CFG_DIV_LSB = 4;
    localparam int unsigned CFG_PWR_LSB = 12;
    localparam int unsigned CFG_TRK_LSB = 16;
    localparam int unsigned CFG_T2_8B = 20;
    localparam int unsigned CFG_T3_8B = 21;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [2:0] RPT_MAX_CODE = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // start sources and states
    localparam logic [2:0] SRC_SW = 3'h0;
    localparam logic [2:0] SRC_T0 = 3'h1;
    localparam logic [2:0] SRC_T2 = 3'h2;
    localparam logic [2:0] SRC_T3 = 3'h3;
    localparam logic [2:0] SRC_EXT = 3'h4;
    localparam logic [2:0] SRC_T1 = 3'h5;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PWRUP = 2'b01,
        ST_TRACK = 2'b11,
        ST_CONV = 2'b10
    } ats_state_t;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic t0;
        logic t1;
        logic t2_lo;
        logic t2_hi;
        logic t3_lo;
        logic t3_hi;
    } ats_tmr_ovf_t;
    typedef struct packed {
        logic power;
        logic track;
        logic convert;
        logic step;
    } ats_ana_t;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } ats_axil_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ats_axil_rsp_t;
endpackage

//--- hw/ats_tick_div.sv
`timescale 1ns/10ps
module ats_tick_div
    import ats_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [7:0] div_m1,
    output logic tick
);
    // ==========================================================
    // divider: one-cycle enable every div_m1+1 cycles while run
    logic [7:0] cnt_q;
    wire wrap = (cnt_q >= div_m1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
            tick <= wrap;
        end
    end
endmodule

//--- hw/ats_seq.sv
`timescale 1ns/10ps
// Functional notes
// - non-burst, low-power clear: track continuously except while converting
// - low-power select: three SAR clocks of tracking after each start
// - pin source in low-power mode: track while pin low, convert on rise
// - codes 000,001,010,011,101 select software write or timer overflows
// - standby or sleep shuts tracking and power off
// - burst: start wakes converter, series runs on ~20 MHz clock, then sleeps
// - repeat count 1,4,8,16,32,64 with results summed in accumulator
// - burst clock independent of the system clock rate
// - burst idle state: enable zero powers down, one stays enabled
// - powered-down start waits power-up time; enabled start tracks at once
// - burst: one start, repeat-count conversions; non-burst: one per start
// - done flag only after repeat-count conversions accumulated
// - window compare only after full repeat-count series
// - burst tracking set by power-up time and burst track time fields
// - low-power select adds three SAR clocks on top of burst settings
// - burst with pin source: one conversion per rising edge
// - busy reads one from start until idle; done flag sets as the series' last conversion ends
// - timer 2/3 source: low overflow in 8-bit mode, high in 16-bit
module ats_seq
    import ats_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire ats_axil_req_t axi_req,
    output ats_axil_rsp_t axi_rsp,
    input wire ats_tmr_ovf_t tmr_ovf,
    input wire logic ext_convert_start_pin,
    input wire logic standby_req,
    input wire logic [DATA_W-1:0] sar_data,
    output ats_ana_t ana,
    output logic conv_done_flag
);
    // ==========================================================
    // registers
    logic converter_enable_q, burst_enable_q, low_power_track_sel_q, win_flag_q;
    logic [2:0] start_source_sel_q;
    logic [31:0] cfg_q;
    logic [ACC_W-1:0] win_gt_q, win_lt_q, result_q, acc_q;
    logic [6:0] series_q;
    logic [7:0] cnt_q;
    ats_state_t state_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, wmask_q;

    // ==========================================================
    // pin synchroniser, s1 feeds s2 only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_convert_start_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    wire ext_rise = ext_s2_q & ~ext_s3_q;

    // ==========================================================
    // bus slave
    wire aw_take = axi_req.awvalid & axi_rsp.awready;
    wire w_take = axi_req.wvalid & axi_rsp.wready;
    wire wr_fire = aw_hold_q & w_hold_q & ~axi_rsp.bvalid;
    wire aw_hold_d = aw_take | (aw_hold_q & ~wr_fire);
    wire w_hold_d = w_take | (w_hold_q & ~wr_fire);
    wire bvalid_d = wr_fire | (axi_rsp.bvalid & ~axi_req.bready);
    wire ar_take = axi_req.arvalid & axi_rsp.arready;
    wire rvalid_d = ar_take | (axi_rsp.rvalid & ~axi_req.rready);
    wire [31:0] wstrb_mask = {{8{axi_req.wstrb[3]}}, {8{axi_req.wstrb[2]}},
                              {8{axi_req.wstrb[1]}}, {8{axi_req.wstrb[0]}}};
    wire wr_ctrl = wr_fire & (awaddr_q == OFS_CTRL);
    wire wr_cfg = wr_fire & (awaddr_q == OFS_CFG);
    wire wr_gt = wr_fire & (awaddr_q == OFS_WIN_GT);
    wire wr_lt = wr_fire & (awaddr_q == OFS_WIN_LT);
    wire wr_hit = wr_ctrl | wr_cfg | wr_gt | wr_lt;
    wire [31:0] wnew = wdata_q & wmask_q;
    wire [31:0] ctrl_rd;
    wire [31:0] status_rd = {21'h0, series_q, state_q, win_flag_q, ana.power};
    wire [7:0] ra = axi_req.araddr;
    wire rd_hit = (ra == OFS_CTRL) | (ra == OFS_CFG) | (ra == OFS_WIN_GT) |
                  (ra == OFS_WIN_LT) | (ra == OFS_RESULT) | (ra == OFS_STATUS);
    wire [31:0] rd_mux = (ra == OFS_CTRL) ? ctrl_rd :
                         (ra == OFS_CFG) ? cfg_q :
                         (ra == OFS_WIN_GT) ? {16'h0, win_gt_q} :
                         (ra == OFS_WIN_LT) ? {16'h0, win_lt_q} :
                         (ra == OFS_RESULT) ? {16'h0, result_q} :
                         (ra == OFS_STATUS) ? status_rd : 32'h0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wmask_q <= 32'h0;
            axi_rsp <= '0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            if (aw_take) awaddr_q <= axi_req.awaddr;
            if (w_take) begin
                wdata_q <= axi_req.wdata;
                wmask_q <= wstrb_mask;
            end
            axi_rsp.awready <= ~aw_hold_d & ~bvalid_d;
            axi_rsp.wready <= ~w_hold_d & ~bvalid_d;
            axi_rsp.bvalid <= bvalid_d;
            if (wr_fire) axi_rsp.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            axi_rsp.arready <= ~rvalid_d;
            axi_rsp.rvalid <= rvalid_d;
            if (ar_take) begin
                axi_rsp.rdata <= rd_mux;
                axi_rsp.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // start selection and configuration decode
    wire [4:0] sar_div = cfg_q[CFG_DIV_LSB +: 5];
    wire [3:0] pwrup_field = cfg_q[CFG_PWR_LSB +: 4];
    wire [3:0] trk_field = cfg_q[CFG_TRK_LSB +: 4];
    wire [2:0] rpt_code = cfg_q[CFG_RPT_LSB +: 3];
    wire [2:0] rpt_shift = (rpt_code == 3'h0 || rpt_code > RPT_MAX_CODE) ? 3'h0 :
                           rpt_code + 3'h1;
    wire [6:0] rpt_n = 7'h01 << rpt_shift;
    wire sw_start = wr_ctrl & wmask_q[CTRL_BUSY] & wdata_q[CTRL_BUSY];
    wire t2_ovf = cfg_q[CFG_T2_8B] ? tmr_ovf.t2_lo : tmr_ovf.t2_hi;
    wire t3_ovf = cfg_q[CFG_T3_8B] ? tmr_ovf.t3_lo : tmr_ovf.t3_hi;
    wire start_ev = (start_source_sel_q == SRC_SW) ? sw_start :
                    (start_source_sel_q == SRC_T0) ? tmr_ovf.t0 :
                    (start_source_sel_q == SRC_T2) ? t2_ovf :
                    (start_source_sel_q == SRC_T3) ? t3_ovf :
                    (start_source_sel_q == SRC_EXT) ? ext_rise :
                    (start_source_sel_q == SRC_T1) ? tmr_ovf.t1 : 1'b0;
    wire ext_src = (start_source_sel_q == SRC_EXT);
    wire ext_lp = ext_src & low_power_track_sel_q & ~burst_enable_q;
    wire accept = start_ev & (state_q == ST_IDLE) & ~standby_req &
                  (burst_enable_q | converter_enable_q);
    wire new_series = (series_q == 7'h00);
    wire [7:0] lp_add = low_power_track_sel_q ? LP_TRACK_CLKS : 8'h00;
    wire [7:0] trk_len = {4'h0, trk_field} + 8'h01 + lp_add;
    wire [7:0] pwr_len = ({4'h0, pwrup_field} << PWRUP_SHIFT) + 8'h01;
    wire busy = (state_q != ST_IDLE);

    // ==========================================================
    // conversion clock: burst uses its own fixed-rate tick
    wire [7:0] div_m1 = burst_enable_q ? BURST_DIV_M1 : {3'h0, sar_div};
    wire tick;
    ats_tick_div u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(busy),
        .div_m1(div_m1),
        .tick(tick)
    );

    // ==========================================================
    // sequencer
    wire step_end = tick & (cnt_q == 8'h01);
    wire conv_end = (state_q == ST_CONV) & step_end;
    wire [6:0] series_inc = series_q + 7'h01;
    wire series_end = conv_end & (series_inc >= rpt_n);
    wire [ACC_W-1:0] acc_sum = acc_q + {{(ACC_W-DATA_W){1'b0}}, sar_data};
    // pin-started bursts stop after each edge so the count spans edges
    wire burst_more = burst_enable_q & ~ext_src;
    wire done_set = series_end;
    wire win_hit = (acc_sum > win_gt_q) & (acc_sum < win_lt_q);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            series_q <= 7'h00;
            acc_q <= '0;
            result_q <= '0;
            win_flag_q <= 1'b0;
        end else if (standby_req) begin
            state_q <= ST_IDLE;
            series_q <= 7'h00;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        if (new_series) acc_q <= '0;
                        if (burst_enable_q && !converter_enable_q) begin
                            state_q <= ST_PWRUP;
                            cnt_q <= pwr_len;
                        end else if (burst_enable_q ||
                                     (low_power_track_sel_q && !ext_lp)) begin
                            state_q <= ST_TRACK;
                            cnt_q <= burst_enable_q ? trk_len : LP_TRACK_CLKS;
                        end else begin
                            state_q <= ST_CONV;
                            cnt_q <= CONV_CLKS;
                        end
                    end
                end
                ST_PWRUP, ST_TRACK: begin
                    if (tick) cnt_q <= cnt_q - 8'h01;
                    if (step_end) begin
                        state_q <= (state_q == ST_PWRUP) ? ST_TRACK : ST_CONV;
                        cnt_q <= (state_q == ST_PWRUP) ? trk_len : CONV_CLKS;
                    end
                end
                ST_CONV: begin
                    if (tick) cnt_q <= cnt_q - 8'h01;
                    if (conv_end) begin
                        acc_q <= acc_sum;
                        series_q <= series_end ? 7'h00 : series_inc;
                        if (series_end) begin
                            result_q <= acc_sum;
                            win_flag_q <= win_hit;
                        end
                        if (burst_more && !series_end) begin
                            state_q <= ST_TRACK;
                            cnt_q <= trk_len;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // control register; hardware set beats software clear
    assign ctrl_rd = {21'h0, start_source_sel_q, converter_enable_q, burst_enable_q,
                      conv_done_flag, busy, win_flag_q, low_power_track_sel_q, 2'h0};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            converter_enable_q <= 1'b0;
            burst_enable_q <= 1'b0;
            low_power_track_sel_q <= 1'b0;
            start_source_sel_q <= SRC_SW;
            conv_done_flag <= 1'b0;
            cfg_q <= CFG_RST;
            win_gt_q <= '0;
            win_lt_q <= '0;
        end else begin
            if (wr_ctrl) begin
                converter_enable_q <= (wnew[CTRL_EN]) | (converter_enable_q & ~wmask_q[CTRL_EN]);
                burst_enable_q <= wnew[CTRL_BURST] | (burst_enable_q & ~wmask_q[CTRL_BURST]);
                low_power_track_sel_q <= wnew[CTRL_LPT] |
                                         (low_power_track_sel_q & ~wmask_q[CTRL_LPT]);
                if (wmask_q[CTRL_SRC_LSB]) start_source_sel_q <= wnew[CTRL_SRC_LSB +: 3];
            end
            if (done_set) conv_done_flag <= 1'b1;
            else if (wr_ctrl && wmask_q[CTRL_DONE]) conv_done_flag <= wnew[CTRL_DONE];
            if (wr_cfg) cfg_q <= wnew | (cfg_q & ~wmask_q);
            if (wr_gt) win_gt_q <= wnew[ACC_W-1:0] | (win_gt_q & ~wmask_q[ACC_W-1:0]);
            if (wr_lt) win_lt_q <= wnew[ACC_W-1:0] | (win_lt_q & ~wmask_q[ACC_W-1:0]);
        end
    end

    // ==========================================================
    // analog controls
    wire idle_track = converter_enable_q & (low_power_track_sel_q ? (ext_lp & ~ext_s2_q) : 1'b1);
    wire track_d = ~standby_req & ((state_q == ST_TRACK) |
                   (~burst_enable_q & (state_q == ST_IDLE) & idle_track));
    wire power_d = ~standby_req & (converter_enable_q |
                   (burst_enable_q & busy));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ana <= '0;
        end else begin
            ana.power <= power_d;
            ana.track <= track_d;
            ana.convert <= (state_q == ST_CONV) & ~standby_req;
            ana.step <= tick & (state_q == ST_CONV);
        end
    end

    // ==========================================================
    // checks
    chk_cont_track: assert property (@(posedge sys_clk) disable iff (rst)
        (!burst_enable_q && !low_power_track_sel_q && converter_enable_q && !standby_req &&
         state_q == ST_IDLE) |=> ana.track) else $error("idle tracking missing");
    chk_lp_track: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_TRACK && !burst_enable_q) |-> low_power_track_sel_q)
        else $error("tracking state without low-power select");
    chk_standby_off: assert property (@(posedge sys_clk) disable iff (rst)
        standby_req |=> (!ana.track && !ana.power)) else $error("standby left converter on");
    chk_burst_pwrdn: assert property (@(posedge sys_clk) disable iff (rst)
        (burst_enable_q && !converter_enable_q && state_q == ST_IDLE) |=> !ana.power)
        else $error("burst idle not powered down");
    chk_pwrup_path: assert property (@(posedge sys_clk) disable iff (rst)
        (accept && burst_enable_q && !converter_enable_q) |=> state_q == ST_PWRUP)
        else $error("powered-down start skipped power-up");
    // software may set the flag by hand, so only hardware sets are checked
    chk_done_count: assert property (@(posedge sys_clk) disable iff (rst)
        ($rose(conv_done_flag) && !$past(wr_ctrl)) |->
        ($past(series_inc) >= $past(rpt_n) && $past(conv_end)))
        else $error("done flag before full series");
    chk_window_hold: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(win_flag_q) |-> $past(series_end)) else $error("window updated mid-series");
    chk_ext_one_conv: assert property (@(posedge sys_clk) disable iff (rst)
        (conv_end && ext_src && !standby_req) |=> state_q == ST_IDLE)
        else $error("pin edge gave more than one conversion");
    chk_series_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (accept && new_series) |=> acc_q == '0) else $error("accumulator not cleared");
endmodule

//--- tb/ats_far_model.sv
`timescale 1ns/10ps
module ats_far_model
    import ats_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [2:0] src,
    input wire logic t_lo,
    output ats_tmr_ovf_t tmr_ovf,
    output logic ext_convert_start_pin
);
    // ==========================================================
    // timer overflows and the convert-start pin
    logic [3:0] pin_q;
    // pin low between requests, so the converter may track there
    assign ext_convert_start_pin = pin_q != 4'h0;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tmr_ovf <= '0;
            pin_q <= 4'h0;
        end else begin
            // one pulse per request; the issuer keeps requests hundreds of clocks apart
            tmr_ovf <= {6{fire}} & {src == SRC_T0, src == SRC_T1, src == SRC_T2 && t_lo,
                src == SRC_T2 && !t_lo, src == SRC_T3 && t_lo,
                src == SRC_T3 && !t_lo};
            pin_q <= (fire && src == SRC_EXT) ? 4'h8 : pin_q - 4'(pin_q != 4'h0);
        end
    end
endmodule

//--- tb/ats_seq_test.sv
`timescale 1ns/10ps
module ats_seq_test;
    import ats_pkg::*;
    // ==========================================================
    // sequencer bench
    localparam int CC = int'(CONV_CLKS);
    localparam int BT = int'(BURST_DIV);
    logic sys_clk, rst, fire, t_lo, standby_req, conv_done_flag, ext_convert_start_pin, b, cx;
    logic [2:0] src, c;
    logic [DATA_W-1:0] sar_data;
    logic [31:0] rd, ctrl;
    logic [1:0] rs;
    ats_axil_req_t axi_req;
    ats_axil_rsp_t axi_rsp;
    ats_tmr_ovf_t tmr_ovf;
    ats_ana_t ana;
    int n_fail = 0, samples_checked = 0, n_step = 0, n_trk = 0, n_cyc = 0, s0, t0, tx;
    logic [2:0] srcs [5] = '{SRC_T0, SRC_T2, SRC_T3, SRC_T1, SRC_EXT};
    ats_seq u_ats_seq (.sys_clk(sys_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .tmr_ovf(tmr_ovf), .ext_convert_start_pin(ext_convert_start_pin),
        .standby_req(standby_req), .sar_data(sar_data), .ana(ana),
        .conv_done_flag(conv_done_flag));
    ats_far_model u_ats_far_model (.sys_clk(sys_clk), .rst(rst), .fire(fire), .src(src),
        .t_lo(t_lo), .tmr_ovf(tmr_ovf), .ext_convert_start_pin(ext_convert_start_pin));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_cyc <= n_cyc + 1;
        n_step <= n_step + int'(ana.step === 1'b1);
        n_trk <= n_trk + int'(ana.track === 1'b1);
        if (n_cyc == 90000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        samples_checked++;
        if (seen !== ex) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic int cnt(input logic [2:0] k);
        return (k == 3'h0 || k > 3'h5) ? 1 : 1 << (k + 1);
    endfunction
    // entered just after a rising edge; leaves just after the answering edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ap, wp, dn;
        ap = 1'b1;
        wp = wr;
        dn = 1'b0;
        // an idle edge first, so back-to-back calls never drive a signal twice at once
        @(posedge sys_clk);
        axi_req.awvalid <= wr;
        axi_req.wvalid <= wr;
        axi_req.bready <= wr;
        axi_req.arvalid <= !wr;
        axi_req.rready <= !wr;
        axi_req.awaddr <= a;
        axi_req.araddr <= a;
        axi_req.wdata <= d;
        while (!dn) begin
            @(negedge sys_clk);
            ap = ap && (wr ? axi_rsp.awready : axi_rsp.arready) !== 1'b1;
            wp = wp && axi_rsp.wready !== 1'b1;
            dn = (wr ? axi_rsp.bvalid : axi_rsp.rvalid) === 1'b1;
            rd = wr ? 32'(axi_rsp.bresp) : axi_rsp.rdata;
            rs = axi_rsp.rresp;
            @(posedge sys_clk);
            axi_req.awvalid <= wr && ap;
            axi_req.wvalid <= wp;
            axi_req.arvalid <= !wr && ap;
            axi_req.bready <= wr && !dn;
            axi_req.rready <= !wr && !dn;
        end
    endtask
    task automatic setup(input logic [31:0] cv, input logic [31:0] fv);
        ctrl = cv;
        bus(1'b1, OFS_CTRL, cv);
        bus(1'b1, OFS_CFG, fv);
    endtask
    task automatic run(input logic [2:0] s, input int k, input int per);
        for (int j = 0; j < k; j++) begin
            s0 = n_step;
            if (s == SRC_SW) begin
                bus(1'b1, OFS_CTRL, ctrl | 32'h10);
                bus(1'b0, OFS_CTRL, 32'h0);
                chk("busy", 32'(rd[CTRL_BUSY]), 32'(per != 0));
                // plain mode converts at once; low-power and burst track first
                cx = per != 0 && !ctrl[CTRL_BURST] && !ctrl[CTRL_LPT];
                chk("convert", 32'(ana.convert), 32'(cx));
            end else begin
                src <= s;
                fire <= 1'b1;
                @(posedge sys_clk);
                fire <= 1'b0;
            end
            while (n_step < s0 + per) @(posedge sys_clk);
            // starts stay hundreds of clocks apart, far above the minimum spacing
            repeat (300) @(posedge sys_clk);
            chk("steps", n_step - s0, per);
        end
    endtask
    task automatic fin(input int n);
        chk("done", 32'(conv_done_flag), 32'h1);
        bus(1'b0, OFS_RESULT, 32'h0);
        chk("result", rd, {16'h0, 16'(int'(sar_data) * n)});
    endtask
    initial begin
        {rst, fire, t_lo, standby_req} = 4'b1000;
        src = SRC_SW;
        axi_req = '0;
        axi_req.wstrb = 4'hf;
        c = 3'($urandom(1722));
        sar_data = 10'h1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_rst", rd, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        chk("unmapped_rd", rd, 32'h0);
        chk("unmapped_rresp", 32'(rs), 32'(RESP_SLVERR));
        bus(1'b1, 8'h18, 32'h1);
        chk("unmapped_wr", rd, 32'(RESP_SLVERR));
        $display("registers done");
        sar_data <= DATA_W'($urandom) | 10'h1;
        setup(32'h80, 32'h1);
        bus(1'b1, OFS_WIN_GT, {16'h0, 16'(int'(sar_data) * 4 - 1)});
        bus(1'b1, OFS_WIN_LT, {16'h0, 16'(int'(sar_data) * 4 + 1)});
        run(SRC_SW, 3, CC);
        chk("done_early", 32'(conv_done_flag), 32'h0);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("win_early", 32'(rd[CTRL_WIN]), 32'h0);
        run(SRC_SW, 1, CC);
        fin(4);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("win", 32'(rd[CTRL_WIN]), 32'h1);
        chk("idle_track", 32'(ana.track), 32'h1);
        $display("non-burst done");
        setup(32'h84, 32'h30);
        t0 = n_trk;
        run(SRC_SW, 1, CC);
        chk("lp_track", 32'(n_trk - t0 inside {[11:13]}), 32'h1);
        $display("low-power track done");
        setup({21'h0, SRC_EXT, 8'h84}, 32'h0);
        chk("pin_low_track", 32'(ana.track), 32'h1);
        run(SRC_EXT, 1, CC);
        $display("pin track done");
        // burst, four per series: timers give all four, the pin one per edge
        foreach (srcs[i]) begin
            b = 1'($urandom);
            sar_data <= DATA_W'($urandom) | 10'h1;
            setup({21'h0, srcs[i], 8'h40}, {10'h0, b, b, 20'h1});
            if (srcs[i] == SRC_T2 || srcs[i] == SRC_T3) begin
                t_lo <= !b;
                run(srcs[i], 1, 0);
                t_lo <= b;
            end
            run(srcs[i], srcs[i] == SRC_EXT ? 4 : 1,
                srcs[i] == SRC_EXT ? CC : 4 * CC);
            fin(4);
        end
        $display("sources done");
        c = 3'($urandom % 6);
        sar_data <= DATA_W'($urandom) | 10'h1;
        for (int e = 0; e < 2; e++) begin
            // track field 2 gives three ticks; low-power select adds three more
            setup(e ? 32'hc4 : 32'h40, 32'(c) | 32'h0002_0000);
            tx = BT * cnt(c) * (3 + e * int'(LP_TRACK_CLKS));
            t0 = n_trk;
            run(SRC_SW, 1, CC * cnt(c));
            fin(cnt(c));
            chk("idle_power", 32'(ana.power), 32'(e));
            chk("burst_track", 32'((n_trk - t0) inside {[tx:tx+1]}), 32'h1);
        end
        $display("burst done");
        standby_req <= 1'b1;
        setup(32'h80, 32'h0);
        run(SRC_SW, 1, 0);
        chk("standby_off", {29'h0, ana.convert, ana.power, ana.track}, 32'h0);
        standby_req <= 1'b0;
        $display("standby done");
        tally_and_finish();
    end
endmodule
